// ===== hw/downstream_address_remap_regs.sv
// Purpose: downstream address remap configuration registers of the bridge
// Assumes: one clock, plain strobe register port, read data one cycle after strobe
// Notes:   all stored fields drive the translation datapath directly from flops
//
// The plain strobed port was decided locally.

`timescale 1ns/1ps

module downstream_address_remap_regs #(
	parameter int AW = remap_regs_pkg::ADDR_WIDTH // register port address width
) (
	input  wire logic          clk,                          // system clock, 10 MHz
	input  wire logic          rst,                          // synchronous reset
	input  wire logic          ce,                           // clock enable
	input  wire logic [AW-1:0] addr,                         // byte address
	input  wire logic [31:0]   wdata,                        // write data
	input  wire logic          wr,                           // write strobe
	input  wire logic          rd,                           // read strobe
	output logic      [31:0]   rdata,                        // read data, cycle after rd
	output logic      [11:0]   secondary_nonpref_lower_base, // np lower base field
	output logic      [4:0]    io_drop_bits,                 // upper I/O bits to drop
	output logic               nonpref_remap_enable,         // np remapping on
	output logic      [11:0]   secondary_pref_lower_base,    // pref lower base field
	output logic               pref_remap_enable,            // pref remapping on
	output logic      [31:0]   secondary_nonpref_upper_base, // secondary np upper base
	output logic      [31:0]   secondary_pref_upper_base,    // secondary pref upper base
	output logic      [31:0]   primary_nonpref_upper_base,   // primary np upper base
	output logic      [31:0]   primary_nonpref_upper_limit,  // primary np upper limit
	output logic               settings_updated,             // pulse after a mapped write
	output logic               unmapped_access               // pulse after unmapped access
);

	// exact word match; a misaligned address never hits
	function automatic logic addr_hit(input logic [AW-1:0] a, input logic [11:0] off);
		addr_hit = (a == AW'(off));
	endfunction

	// per-register hit lines
	logic hit_np_ctrl;    // non-prefetchable control
	logic hit_np_ubase;   // secondary np upper base
	logic hit_pf_ctrl;    // prefetchable control
	logic hit_pf_ubase;   // secondary pref upper base
	logic hit_pri_ubase;  // primary np upper base
	logic hit_pri_ulimit; // primary np upper limit
	logic any_hit;        // address maps to a register

	// stored words
	logic [31:0] np_ctrl_word;    // non-prefetchable control word
	logic [31:0] np_ubase_word;   // secondary np upper base word
	logic [31:0] pf_ctrl_word;    // prefetchable control word
	logic [31:0] pf_ubase_word;   // secondary pref upper base word
	logic [31:0] pri_ubase_word;  // primary np upper base word
	logic [31:0] pri_ulimit_word; // primary np upper limit word

	// read mux result
	logic [31:0] next_rdata; // value to present after a read

	// address decode, one comparison per register
	always_comb begin
		hit_np_ctrl    = addr_hit(addr, remap_regs_pkg::OFF_SEC_NONPREF_REMAP_CONTROL);
		hit_np_ubase   = addr_hit(addr, remap_regs_pkg::OFF_SEC_NONPREF_UPPER_BASE);
		hit_pf_ctrl    = addr_hit(addr, remap_regs_pkg::OFF_SEC_PREF_REMAP_CONTROL);
		hit_pf_ubase   = addr_hit(addr, remap_regs_pkg::OFF_SEC_PREF_UPPER_BASE);
		hit_pri_ubase  = addr_hit(addr, remap_regs_pkg::OFF_PRI_NONPREF_UPPER_BASE);
		hit_pri_ulimit = addr_hit(addr, remap_regs_pkg::OFF_PRI_NONPREF_UPPER_LIMIT);
		any_hit        = hit_np_ctrl | hit_np_ubase | hit_pf_ctrl
		               | hit_pf_ubase | hit_pri_ubase | hit_pri_ulimit;
	end

	// non-prefetchable control: base, drop count, enable; reserved bits masked off
	remap_word_reg #(
		.RESET_VALUE (remap_regs_pkg::RST_SEC_NONPREF_REMAP_CONTROL),
		.WRITE_MASK  (remap_regs_pkg::WMASK_NONPREF_CONTROL)
	) u_np_ctrl (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.write_en (wr && hit_np_ctrl),
		.wdata    (wdata),
		.q        (np_ctrl_word)
	);

	// secondary non-prefetchable upper base, whole word writable
	remap_word_reg #(
		.RESET_VALUE (remap_regs_pkg::RST_SEC_NONPREF_UPPER_BASE),
		.WRITE_MASK  (remap_regs_pkg::WMASK_FULL_WORD)
	) u_np_ubase (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.write_en (wr && hit_np_ubase),
		.wdata    (wdata),
		.q        (np_ubase_word)
	);

	// prefetchable control: base and enable, 19:4 and 2:0 reserved
	remap_word_reg #(
		.RESET_VALUE (remap_regs_pkg::RST_SEC_PREF_REMAP_CONTROL),
		.WRITE_MASK  (remap_regs_pkg::WMASK_PREF_CONTROL)
	) u_pf_ctrl (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.write_en (wr && hit_pf_ctrl),
		.wdata    (wdata),
		.q        (pf_ctrl_word)
	);

	// secondary prefetchable upper base, whole word writable
	remap_word_reg #(
		.RESET_VALUE (remap_regs_pkg::RST_SEC_PREF_UPPER_BASE),
		.WRITE_MASK  (remap_regs_pkg::WMASK_FULL_WORD)
	) u_pf_ubase (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.write_en (wr && hit_pf_ubase),
		.wdata    (wdata),
		.q        (pf_ubase_word)
	);

	// primary non-prefetchable upper base
	remap_word_reg #(
		.RESET_VALUE (remap_regs_pkg::RST_PRI_NONPREF_UPPER_BASE),
		.WRITE_MASK  (remap_regs_pkg::WMASK_FULL_WORD)
	) u_pri_ubase (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.write_en (wr && hit_pri_ubase),
		.wdata    (wdata),
		.q        (pri_ubase_word)
	);

	// primary non-prefetchable upper limit
	remap_word_reg #(
		.RESET_VALUE (remap_regs_pkg::RST_PRI_NONPREF_UPPER_LIMIT),
		.WRITE_MASK  (remap_regs_pkg::WMASK_FULL_WORD)
	) u_pri_ulimit (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.write_en (wr && hit_pri_ulimit),
		.wdata    (wdata),
		.q        (pri_ulimit_word)
	);

	// read mux; words already hold zero in reserved bits, so no extra masking
	always_comb begin
		if (hit_np_ctrl) begin
			next_rdata = np_ctrl_word;
		end else if (hit_np_ubase) begin
			next_rdata = np_ubase_word;
		end else if (hit_pf_ctrl) begin
			next_rdata = pf_ctrl_word;
		end else if (hit_pf_ubase) begin
			next_rdata = pf_ubase_word;
		end else if (hit_pri_ubase) begin
			next_rdata = pri_ubase_word;
		end else if (hit_pri_ulimit) begin
			next_rdata = pri_ulimit_word;
		end else begin
			// unmapped: defined answer rather than stale data
			next_rdata = remap_regs_pkg::UNMAPPED_READ_VALUE;
		end
	end

	// read data stands in the cycle after a taken strobe, zero after an enabled cycle without rd, held while ce is low
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (ce) begin
			if (rd) begin
				rdata <= next_rdata;
			end else begin
				rdata <= 32'h0000_0000;
			end
		end
	end

	// field views for the translation datapath; these are flop outputs, no logic
	always_comb begin
		secondary_nonpref_lower_base = np_ctrl_word[remap_regs_pkg::LOWER_BASE_MSB:
		                                            remap_regs_pkg::LOWER_BASE_LSB];
		io_drop_bits                 = np_ctrl_word[remap_regs_pkg::IO_DROP_MSB:
		                                            remap_regs_pkg::IO_DROP_LSB];
		nonpref_remap_enable         = np_ctrl_word[remap_regs_pkg::REMAP_EN_BIT];
		secondary_pref_lower_base    = pf_ctrl_word[remap_regs_pkg::LOWER_BASE_MSB:
		                                            remap_regs_pkg::LOWER_BASE_LSB];
		pref_remap_enable            = pf_ctrl_word[remap_regs_pkg::REMAP_EN_BIT];
		secondary_nonpref_upper_base = np_ubase_word;
		secondary_pref_upper_base    = pf_ubase_word;
		primary_nonpref_upper_base   = pri_ubase_word;
		primary_nonpref_upper_limit  = pri_ulimit_word;
	end

	// update pulse lets the datapath re-latch its compare windows;
	// it trails the stored value by nothing, both change on the same edge
	always_ff @(posedge clk) begin
		if (rst) begin
			settings_updated <= 1'b0;
		end else if (ce) begin
			settings_updated <= wr && any_hit;
		end
	end

	// unmapped access pulse, for either strobe; the access itself is harmless
	always_ff @(posedge clk) begin
		if (rst) begin
			unmapped_access <= 1'b0;
		end else if (ce) begin
			unmapped_access <= (wr || rd) && !any_hit;
		end
	end

endmodule // downstream_address_remap_regs

// ===== hw/remap_word_reg.sv
// Purpose: one 32-bit configuration word with per-bit write mask
// Assumes: synchronous active-high reset, clock enable freezes the word
// Notes:   bits outside the mask keep their reset value forever

`timescale 1ns/1ps

module remap_word_reg #(
	parameter logic [31:0] RESET_VALUE = 32'h0000_0000, // value after reset
	parameter logic [31:0] WRITE_MASK  = 32'hffff_ffff  // writable bit positions
) (
	input  wire logic        clk,      // system clock
	input  wire logic        rst,      // synchronous reset
	input  wire logic        ce,       // clock enable
	input  wire logic        write_en, // write this word
	input  wire logic [31:0] wdata,    // write data
	output logic      [31:0] q         // stored word
);

	// masked update: reserved bits never leave their reset value
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= RESET_VALUE;
		end else if (ce && write_en) begin
			q <= (q & ~WRITE_MASK) | (wdata & WRITE_MASK);
		end
	end

endmodule // remap_word_reg

// ===== pkg/remap_regs_pkg.sv
// Purpose: constants for the downstream address remap register set
// Assumes: byte addresses on the register port, one aligned 32-bit word per register
// Notes:   offsets, field positions, reset values and writable masks of the design live here only; the tests write their own
//
// What this block does
// - non-prefetchable control: 12-bit lower base at 31:20
// - non-prefetchable control: 5-bit I/O drop count 12:8
// - non-prefetchable control bit 3 enables remapping
// - prefetchable control: lower base 31:20, 19:4 reserved
// - prefetchable control bit 3 enables prefetchable remapping
// - secondary non-prefetchable upper base, 32-bit read-write
// - primary non-prefetchable upper base, 32-bit read-write
// - primary non-prefetchable upper limit, 32-bit read-write
// - control reserved bits 19:13, 7:4, 2:0 read zero

package remap_regs_pkg;

	// address width of the register port
	localparam int ADDR_WIDTH = 12;

	// register byte offsets
	localparam logic [11:0] OFF_SEC_NONPREF_REMAP_CONTROL = 12'h0e4;
	localparam logic [11:0] OFF_SEC_NONPREF_UPPER_BASE    = 12'h0e8;
	localparam logic [11:0] OFF_SEC_PREF_REMAP_CONTROL    = 12'h0ec;
	localparam logic [11:0] OFF_SEC_PREF_UPPER_BASE       = 12'h0f0;
	localparam logic [11:0] OFF_PRI_NONPREF_UPPER_BASE    = 12'h0f4;
	localparam logic [11:0] OFF_PRI_NONPREF_UPPER_LIMIT   = 12'h0f8;

	// reset values, all registers clear
	localparam logic [31:0] RST_SEC_NONPREF_REMAP_CONTROL = 32'h0000_0000;
	localparam logic [31:0] RST_SEC_NONPREF_UPPER_BASE    = 32'h0000_0000;
	localparam logic [31:0] RST_SEC_PREF_REMAP_CONTROL    = 32'h0000_0000;
	localparam logic [31:0] RST_SEC_PREF_UPPER_BASE       = 32'h0000_0000;
	localparam logic [31:0] RST_PRI_NONPREF_UPPER_BASE    = 32'h0000_0000;
	localparam logic [31:0] RST_PRI_NONPREF_UPPER_LIMIT   = 32'h0000_0000;

	// writable bits per register; cleared positions are reserved
	localparam logic [31:0] WMASK_NONPREF_CONTROL = 32'hfff0_1f08;
	localparam logic [31:0] WMASK_PREF_CONTROL    = 32'hfff0_0008;
	localparam logic [31:0] WMASK_FULL_WORD       = 32'hffff_ffff;

	// field positions inside the control words
	localparam int LOWER_BASE_LSB = 20;
	localparam int LOWER_BASE_MSB = 31;
	localparam int IO_DROP_LSB    = 8;
	localparam int IO_DROP_MSB    = 12;
	localparam int REMAP_EN_BIT   = 3;

	// answer for an unmapped read
	localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;

endpackage

// ===== test/remap_regs_props.sv
// Purpose: port-level checks of the downstream remap register set
// Assumes: one clock, synchronous active-high reset, read data one cycle after rd
// Notes:   watches design ports only; bound from the bench top file

`timescale 1ns/1ps

module remap_regs_props #(
	parameter int AW = 12 // register port address width
) (
	input wire logic          clk,
	input wire logic          rst,
	input wire logic          ce,
	input wire logic [AW-1:0] addr,
	input wire logic [31:0]   wdata,
	input wire logic          wr,
	input wire logic          rd,
	input wire logic [31:0]   rdata,
	input wire logic [11:0]   secondary_nonpref_lower_base,
	input wire logic [4:0]    io_drop_bits,
	input wire logic          nonpref_remap_enable,
	input wire logic [11:0]   secondary_pref_lower_base,
	input wire logic          pref_remap_enable,
	input wire logic [31:0]   secondary_nonpref_upper_base,
	input wire logic [31:0]   primary_nonpref_upper_base,
	input wire logic [31:0]   primary_nonpref_upper_limit,
	input wire logic          unmapped_access
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic        wr_np;   // taken write to the np control word
	logic        wr_pf;   // taken write to the pref control word
	logic [31:0] np_word; // np control rebuilt from its field outputs
	logic [31:0] pf_word; // pref control rebuilt from its field outputs
	assign wr_np = ce && wr && addr == 12'h0e4;
	assign wr_pf = ce && wr && addr == 12'h0ec;
	assign np_word = {secondary_nonpref_lower_base, 7'h00, io_drop_bits, 4'h0,
		nonpref_remap_enable, 3'h0};
	assign pf_word = {secondary_pref_lower_base, 16'h0000, pref_remap_enable, 3'h0};

	np_base_a: assert property (wr_np |=> (np_word & 32'hfff0_0000) ==
		($past(wdata) & 32'hfff0_0000)) else $error("np lower base not loaded");
	np_drop_a: assert property (wr_np |=> (np_word & 32'h0000_1f00) ==
		($past(wdata) & 32'h0000_1f00)) else $error("io drop count not loaded");
	np_enable_a: assert property (wr_np |=> nonpref_remap_enable == $past(wdata[3]))
		else $error("np enable not loaded");
	pf_ctrl_a: assert property (wr_pf |=> pf_word == ($past(wdata) & 32'hfff0_0008))
		else $error("pref control wrong");
	sec_base_a: assert property (ce && wr && addr == 12'h0e8 |=>
		secondary_nonpref_upper_base == $past(wdata)) else $error("sec upper base wrong");
	pri_base_a: assert property (ce && wr && addr == 12'h0f4 |=>
		primary_nonpref_upper_base == $past(wdata)) else $error("pri upper base wrong");
	pri_limit_a: assert property (ce && wr && addr == 12'h0f8 |=>
		primary_nonpref_upper_limit == $past(wdata)) else $error("pri upper limit wrong");
	np_read_a: assert property (ce && rd && addr == 12'h0e4 |=> rdata == np_word)
		else $error("np control readback wrong");
	rdata_idle_a: assert property (ce && !rd |=> rdata == 32'h0000_0000)
		else $error("read data not cleared");
	limit_hold_a: assert property (!(ce && wr) |=> $stable(primary_nonpref_upper_limit))
		else $error("limit changed without write");
	unmapped_a: assert property (ce && (wr || rd) && addr[1:0] != 2'b00 |=> unmapped_access)
		else $error("misaligned access not flagged");
endmodule // remap_regs_props

// ===== test/tb_downstream_address_remap_regs.sv
// Purpose: directed bench for the downstream remap register set
// Assumes: strobe register port, read data in the cycle after rd only
// Notes:   expectations come from masks and offsets written out here

`timescale 1ns/1ps

module tb_downstream_address_remap_regs;
	logic        clk = 1'b0;             // 10 MHz clock
	logic        rst = 1'b1;             // held from time zero
	logic        ce = 1'b1;              // clock enable
	logic        wr = 1'b0;              // write strobe
	logic        rd = 1'b0;              // read strobe
	logic [11:0] addr = 12'h000;         // byte address
	logic [31:0] wdata = 32'h0000_0000;  // write data
	logic [31:0] rdata, npu, pfu, pru, prl; // read data and upper words
	logic [11:0] npl, pfl;               // lower base fields
	logic [4:0]  iod;                    // io drop count
	logic        npe, pfe, upd, unm;     // enables and pulses
	int          fails = 0;
	int          compares = 0;
	logic [11:0] offs [6] = '{12'h0e4, 12'h0e8, 12'h0ec, 12'h0f0, 12'h0f4, 12'h0f8};
	logic [11:0] wofs [4] = '{12'h0e8, 12'h0f0, 12'h0f4, 12'h0f8};

	// half period of 50 ns
	always #50 clk = ~clk;

	downstream_address_remap_regs dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.secondary_nonpref_lower_base(npl), .io_drop_bits(iod), .nonpref_remap_enable(npe),
		.secondary_pref_lower_base(pfl), .pref_remap_enable(pfe),
		.secondary_nonpref_upper_base(npu), .secondary_pref_upper_base(pfu),
		.primary_nonpref_upper_base(pru), .primary_nonpref_upper_limit(prl),
		.settings_updated(upd), .unmapped_access(unm));

	task automatic print_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// one strobe cycle; returns just after the taking edge, so pulses are visible
	task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		access(1'b0, a, 32'h0000_0000);
		cmp("rdata", e, rdata);
	endtask

	// reset, then every word and field must read zero
	task automatic t_reset(input int n);
		@(posedge clk);
		rst <= 1'b1;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		foreach (offs[i]) rd_chk(offs[i], 32'h0000_0000);
		cmp("fields", 32'h0000_0000,
			npu | pfu | pru | prl | {npl, pfl, iod, npe, pfe});
	endtask

	// all ones, then a pattern with reserved bits set
	task automatic t_np();
		access(1'b1, 12'h0e4, 32'hffff_ffff);
		cmp("updated", 32'h0000_0001, upd);
		cmp("np fields", {12'hfff, 5'h1f, 1'b1}, {npl, iod, npe});
		rd_chk(12'h0e4, 32'hfff0_1f08);
		access(1'b1, 12'h0e4, 32'h5a61_0af7);
		cmp("np fields", {12'h5a6, 5'h0a, 1'b0}, {npl, iod, npe});
		rd_chk(12'h0e4, 32'h5a60_0a00);
	endtask

	task automatic t_pf();
		access(1'b1, 12'h0ec, 32'hffff_ffff);
		cmp("pf fields", {12'hfff, 1'b1}, {pfl, pfe});
		rd_chk(12'h0ec, 32'hfff0_0008);
		cmp("np fields", {12'h5a6, 5'h0a, 1'b0}, {npl, iod, npe});
		access(1'b1, 12'h0ec, 32'h000f_fff7);
		cmp("pf fields", 32'h0000_0000, {pfl, pfe});
	endtask

	// distinct values expose any aliasing between the full words
	task automatic t_words();
		for (int i = 0; i < 4; i++) access(1'b1, wofs[i], 32'hc3a5_0f00 + i);
		cmp("np upper", 32'hc3a5_0f00, npu);
		cmp("pf upper", 32'hc3a5_0f01, pfu);
		cmp("pri base", 32'hc3a5_0f02, pru);
		cmp("pri limit", 32'hc3a5_0f03, prl);
		for (int i = 0; i < 4; i++) rd_chk(wofs[i], 32'hc3a5_0f00 + i);
	endtask

	task automatic t_bad();
		access(1'b1, 12'h0ea, 32'hffff_ffff);
		cmp("unmapped", 32'h0000_0001, unm);
		cmp("np upper", 32'hc3a5_0f00, npu);
		rd_chk(12'h0fc, 32'h0000_0000);
		cmp("unmapped", 32'h0000_0001, unm);
	endtask

	// a frozen write must not land
	task automatic t_ce();
		@(posedge clk);
		ce <= 1'b0;
		access(1'b1, 12'h0f8, 32'hffff_ffff);
		@(posedge clk);
		ce <= 1'b1;
		cmp("pri limit", 32'hc3a5_0f03, prl);
		access(1'b1, 12'h0f8, 32'hffff_ffff);
		cmp("pri limit", 32'hffff_ffff, prl);
	endtask

	initial begin
		t_reset(19);
		t_np();
		t_pf();
		t_words();
		t_bad();
		t_ce();
		t_reset(2);
		print_verdict();
	end

	// hang guard at 9 ms, about a thousand times the run of under 9 us
	initial begin
		#9_000_000;
		fails++;
		print_verdict();
	end
endmodule // tb_downstream_address_remap_regs

bind downstream_address_remap_regs remap_regs_props #(.AW(AW)) chk (.clk(clk), .rst(rst),
	.ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.secondary_nonpref_lower_base(secondary_nonpref_lower_base), .io_drop_bits(io_drop_bits),
	.nonpref_remap_enable(nonpref_remap_enable), .pref_remap_enable(pref_remap_enable),
	.secondary_pref_lower_base(secondary_pref_lower_base),
	.secondary_nonpref_upper_base(secondary_nonpref_upper_base),
	.primary_nonpref_upper_base(primary_nonpref_upper_base),
	.primary_nonpref_upper_limit(primary_nonpref_upper_limit),
	.unmapped_access(unmapped_access));
